/* core/swd_consts.svh */
// Constants for the system clock watchdog
// What this block does
// - Thirty-bit free-running watchdog counter
// - Expiry raises interrupt or system reset
// - Counter halts in idle or stop
// - Counts slower in reduced clock mode
// - Timeout flag bit 3, software clears
// - Interrupt gated by enable bit 4
// - Reset cause flag bit 2 kept
// - Reset enable bit 1, default on
// - Restart strobe bit 0, lock open
// - Locked restart accepted but ignored
`ifndef SWD_CONSTS_SVH
`define SWD_CONSTS_SVH

`define SWD_ADDR_CLKCTL 8'h8E
`define SWD_ADDR_FLAGCTL 8'hD8
`define SWD_ADDR_XIEN 8'hE8
`define SWD_ADDR_STS 8'hF0
`define SWD_ADDR_MSK 8'hF1

`define SWD_CLKCTL_RST 8'hC7
`define SWD_FLAGCTL_RST 8'h02
`define SWD_RSTEN_RST 1'b1
`define SWD_TOIE_RST 1'b0

`define SWD_BIT_RESTART 0
`define SWD_BIT_RSTEN 1
`define SWD_BIT_CAUSE 2
`define SWD_BIT_TOFLAG 3
`define SWD_BIT_TOIE 4
`define SWD_BIT_SEL2 2
`define SWD_BIT_SEL0 6
`define SWD_BIT_SEL1 7

`define SWD_STS_TIMEOUT 0
`define SWD_STS_WDRST 1
`define SWD_STS_REFUSED 2
`define SWD_STS_W 3

`define SWD_CNT_W 30
`define SWD_SEL_W 3
`define SWD_SHIFT_MAX 5'h0E
`define SWD_SLOW_DIV 8'h40
`define SWD_PRE_W 8

`endif

/* core/swd_pkg.sv */
// Types shared by the system clock watchdog
package swd_pkg;

    typedef struct packed {
        logic idle;
        logic stop;
        logic reduced;
    } swd_pwr_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } swd_req_t;

endpackage

/* core/swd_watchdog.sv */
// System clock watchdog with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "swd_consts.svh"

module swd_watchdog (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire swd_pkg::swd_pwr_t pwr,
    input wire logic lock_open,
    input wire swd_pkg::swd_req_t req,
    output logic [7:0] rdata,
    output logic wdt_irq,
    output logic irq,
    output logic sys_reset
);

    logic [`SWD_CNT_W-1:0] cnt_r;
    logic [`SWD_CNT_W-1:0] cnt_nxt;
    logic [`SWD_CNT_W-1:0] term;
    logic [`SWD_PRE_W-1:0] pre_r;
    logic [7:0] clkctl_r;
    logic toie_r;
    logic rsten_r;
    logic toflag_r;
    logic cause_r;
    logic [`SWD_STS_W-1:0] sts_r;
    logic [`SWD_STS_W-1:0] msk_r;
    logic [`SWD_STS_W-1:0] ev;
    logic [7:0] rdata_r;
    logic [7:0] rd_nxt;
    logic wdt_irq_r;
    logic irq_r;
    logic sys_reset_r;
    logic [`SWD_SEL_W-1:0] sel;
    logic [4:0] shift;
    logic tick;
    logic expire;
    logic wd_rst;
    logic wr_flagctl;
    logic restart_req;
    logic restart;
    logic refused;

    assign sel = {clkctl_r[`SWD_BIT_SEL2], clkctl_r[`SWD_BIT_SEL1],
        clkctl_r[`SWD_BIT_SEL0]};
    // Each select step adds two bits of interval, longest is full width
    assign shift = `SWD_SHIFT_MAX - {1'b0, sel, 1'b0};
    assign term = {`SWD_CNT_W{1'b1}} >> shift;

    // Counter runs off the core clock: no advance while it is gated
    assign tick = ce && !pwr.idle && !pwr.stop &&
        (!pwr.reduced || pre_r == `SWD_SLOW_DIV - 8'h01);
    assign expire = tick && cnt_r == term;
    assign wd_rst = expire && rsten_r;

    assign wr_flagctl = ce && req.wr && req.addr == `SWD_ADDR_FLAGCTL;
    assign restart_req = wr_flagctl && req.wdata[`SWD_BIT_RESTART];
    assign restart = restart_req && lock_open;
    assign refused = restart_req && !lock_open;

    // Prescaler that models the slowed core clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_r <= '0;
        end else if (ce) begin
            if (!pwr.reduced || pwr.idle || pwr.stop) begin
                pre_r <= '0;
            end else if (pre_r == `SWD_SLOW_DIV - 8'h01) begin
                pre_r <= '0;
            end else begin
                pre_r <= pre_r + 8'h01;
            end
        end
    end

    always_comb begin
        cnt_nxt = cnt_r;
        if (restart || wd_rst) begin
            cnt_nxt = '0;
        end else if (expire) begin
            cnt_nxt = '0;
        end else if (tick) begin
            cnt_nxt = cnt_r + 30'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
        end
    end

    // Watchdog reset reloads clock, reset enable and interrupt enable like a system reset; the status mask is kept
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clkctl_r <= `SWD_CLKCTL_RST;
        end else if (ce) begin
            if (wd_rst) begin
                clkctl_r <= `SWD_CLKCTL_RST;
            end else if (req.wr && req.addr == `SWD_ADDR_CLKCTL) begin
                clkctl_r <= req.wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsten_r <= `SWD_RSTEN_RST;
        end else if (ce) begin
            if (wd_rst) begin
                rsten_r <= `SWD_RSTEN_RST;
            end else if (wr_flagctl) begin
                rsten_r <= req.wdata[`SWD_BIT_RSTEN];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            toie_r <= `SWD_TOIE_RST;
        end else if (ce) begin
            if (wd_rst) begin
                toie_r <= `SWD_TOIE_RST;
            end else if (req.wr && req.addr == `SWD_ADDR_XIEN) begin
                toie_r <= req.wdata[`SWD_BIT_TOIE];
            end
        end
    end

    // Expiry wins over a software write in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            toflag_r <= 1'b0;
        end else if (ce) begin
            if (expire) begin
                toflag_r <= 1'b1;
            end else if (wr_flagctl) begin
                toflag_r <= req.wdata[`SWD_BIT_TOFLAG];
            end
        end
    end

    // The hard reset clears the cause flag, a flag register write loads it from bit 2, a watchdog reset sets it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cause_r <= 1'b0;
        end else if (ce) begin
            if (wd_rst) begin
                cause_r <= 1'b1;
            end else if (wr_flagctl) begin
                cause_r <= req.wdata[`SWD_BIT_CAUSE];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_reset_r <= 1'b0;
        end else if (ce) begin
            sys_reset_r <= wd_rst;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_irq_r <= 1'b0;
        end else if (ce) begin
            wdt_irq_r <= toflag_r && toie_r;
        end
    end

    assign ev[`SWD_STS_TIMEOUT] = expire;
    assign ev[`SWD_STS_WDRST] = wd_rst;
    assign ev[`SWD_STS_REFUSED] = refused;

    // Sticky status, write one to clear; a new event beats the clear
    genvar gi;
    generate
        for (gi = 0; gi < `SWD_STS_W; gi = gi + 1) begin : g_sts
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    sts_r[gi] <= 1'b0;
                end else if (ce) begin
                    if (ev[gi]) begin
                        sts_r[gi] <= 1'b1;
                    end else if (req.wr && req.addr == `SWD_ADDR_STS &&
                            req.wdata[gi]) begin
                        sts_r[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msk_r <= '0;
        end else if (ce && req.wr && req.addr == `SWD_ADDR_MSK) begin
            msk_r <= req.wdata[`SWD_STS_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= |(sts_r & msk_r);
        end
    end

    // Restart bit always reads zero, it holds no state
    always_comb begin
        rd_nxt = 8'h00;
        case (req.addr)
            `SWD_ADDR_CLKCTL: begin
                rd_nxt = clkctl_r;
            end
            `SWD_ADDR_FLAGCTL: begin
                rd_nxt = {4'h0, toflag_r, cause_r, rsten_r, 1'b0};
            end
            `SWD_ADDR_XIEN: begin
                rd_nxt = {3'h0, toie_r, 4'h0};
            end
            `SWD_ADDR_STS: begin
                rd_nxt = {5'h00, sts_r};
            end
            `SWD_ADDR_MSK: begin
                rd_nxt = {5'h00, msk_r};
            end
            default: begin
                rd_nxt = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (ce) begin
            rdata_r <= req.rd ? rd_nxt : 8'h00;
        end
    end

    assign rdata = rdata_r;
    assign wdt_irq = wdt_irq_r;
    assign irq = irq_r;
    assign sys_reset = sys_reset_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_cnt_wraps_zero: assert property (
        tick && !restart && cnt_r == {`SWD_CNT_W{1'b1}} |=> cnt_r == '0)
        else $error("Counter did not wrap at full width");

    a_reset_pulse_out: assert property (
        wd_rst |=> sys_reset_r && cause_r && rsten_r)
        else $error("Watchdog reset not issued on expiry");

    a_halt_when_idle: assert property (
        (pwr.idle || pwr.stop) && !restart |=> $stable(cnt_r))
        else $error("Counter moved while core clock stopped");

    a_reduced_rate: assert property (
        ce && pwr.reduced && !pwr.idle && !pwr.stop && !restart &&
        pre_r != `SWD_SLOW_DIV - 8'h01 |=> $stable(cnt_r))
        else $error("Counter advanced off the slow tick");

    a_flag_on_expiry: assert property (
        expire |=> toflag_r ##1 (toflag_r || $past(wr_flagctl)))
        else $error("Timeout flag not set or lost");

    a_irq_gated: assert property (
        ce && !toie_r && !(req.wr && req.addr == `SWD_ADDR_XIEN)
        |=> !wdt_irq_r)
        else $error("Watchdog interrupt while disabled");

    a_cause_kept: assert property (
        cause_r && !wr_flagctl |=> cause_r)
        else $error("Reset cause flag cleared by hardware");

    a_restart_clears: assert property (
        restart |=> cnt_r == '0)
        else $error("Restart did not clear counter");

    a_rd_restart_zero: assert property (
        ce && req.rd && req.addr == `SWD_ADDR_FLAGCTL
        |=> rdata_r[`SWD_BIT_RESTART] == 1'b0)
        else $error("Restart bit read back nonzero");

    a_locked_ignored: assert property (
        refused && tick && cnt_r != term |=> cnt_r == $past(cnt_r) + 30'h1)
        else $error("Locked restart changed the counter");

    a_term_expiry: assert property (
        tick && cnt_r == term && !restart |=> cnt_r == '0 && toflag_r)
        else $error("Terminal count did not expire");

    a_tick_count: assert property (
        tick && !restart && !expire |=> cnt_r == $past(cnt_r) + 30'h1)
        else $error("Counter did not step on a tick");

    a_rdata_idle_zero: assert property (
        ce && !req.rd |=> rdata_r == 8'h00)
        else $error("Read data shown without a read");

    a_reset_one_cycle: assert property (
        ce && sys_reset_r |=> !sys_reset_r)
        else $error("System reset request longer than one cycle");

    a_no_reset_off: assert property (
        expire && !rsten_r |=> !sys_reset_r)
        else $error("System reset issued while disabled");

    // A frozen enable must hold the counter, the timeout flag and the read data output
    a_freeze_on_ce: assert property (
        !ce |=> $stable(cnt_r) && $stable(toflag_r) && $stable(rdata_r))
        else $error("State moved while clock enable low");

    a_refused_status: assert property (
        refused |=> sts_r[`SWD_STS_REFUSED])
        else $error("Locked restart not recorded");

    a_irq_follows: assert property (
        ce |=> wdt_irq_r == $past(toflag_r && toie_r))
        else $error("Watchdog interrupt does not follow flag");

    a_reset_reload: assert property (
        wd_rst |=> clkctl_r == `SWD_CLKCTL_RST && rsten_r && !toie_r)
        else $error("Watchdog reset did not reload controls");

    a_status_irq: assert property (
        ce |=> irq_r == $past(|(sts_r & msk_r)))
        else $error("Status interrupt does not follow status");

    c_expire_irq: cover property (expire && !rsten_r ##[1:4] wdt_irq_r);
    c_expire_reset: cover property (wd_rst ##1 sys_reset_r);
    c_locked_restart: cover property (refused);
    c_open_restart: cover property (restart ##1 cnt_r == '0);
    c_slow_tick: cover property (pwr.reduced && tick);

endmodule
`default_nettype wire

/* verif/test_swd_watchdog.sv */
// Self-checking bench for the system clock watchdog
`timescale 1ns/1ps
`default_nettype none
`include "swd_consts.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("BAD %0t got %h want %h", $time, (a), (b)); end end

module test_swd_watchdog;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    swd_pkg::swd_pwr_t pwr = '0;
    logic lock_open = 1'b0;
    swd_pkg::swd_req_t req = '0;
    logic [7:0] rdata;
    logic wdt_irq;
    logic irq;
    logic sys_reset;
    logic [7:0] d;
    logic [7:0] a;
    logic [7:0] v;
    logic [31:0] seed = 32'h0000_0042;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int t0 = 0;
    int n = 0;
    int want = 0;

    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    swd_watchdog DUT (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pwr(pwr),
        .lock_open(lock_open),
        .req(req),
        .rdata(rdata),
        .wdt_irq(wdt_irq),
        .irq(irq),
        .sys_reset(sys_reset)
    );

    function logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // Cycles from restart to expiry; reduced mode costs 64 cycles a tick
    function int expiry(int sel, int halted, int slow);
        return halted + slow + (1 << (16 + 2 * sel)) - slow / 64;
    endfunction

    task wr(input logic [7:0] ad, input logic [7:0] dat);
        @(posedge clk);
        req.addr <= ad;
        req.wdata <= dat;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task chk_reg(input logic [7:0] ad, input logic [7:0] w);
        @(posedge clk);
        req.addr <= ad;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
        `CHK(d, w)
    endtask

    task results;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (85000) @(posedge clk);
        errors++;
        results();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        chk_reg(`SWD_ADDR_CLKCTL, `SWD_CLKCTL_RST);
        chk_reg(`SWD_ADDR_FLAGCTL, `SWD_FLAGCTL_RST);
        chk_reg(`SWD_ADDR_XIEN, 8'h00);
        a = 8'h20 | (xs() & 8'h0F);
        wr(a, xs());
        chk_reg(a, 8'h00);
        // Shortest timeout select, other bits random
        v = xs() & 8'h3B;
        wr(`SWD_ADDR_CLKCTL, v);
        chk_reg(`SWD_ADDR_CLKCTL, v);
        wr(`SWD_ADDR_MSK, 8'h01);
        $display("test registers done");
        // A restart that failed would expire well before the window
        repeat (2000) @(posedge clk);
        lock_open <= 1'b1;
        wr(`SWD_ADDR_FLAGCTL, 8'h03);
        t0 = cyc;
        lock_open <= 1'b0;
        chk_reg(`SWD_ADDR_FLAGCTL, 8'h02);
        pwr.idle <= 1'b1;
        repeat (500) @(posedge clk);
        pwr.idle <= 1'b0;
        pwr.stop <= 1'b1;
        repeat (500) @(posedge clk);
        pwr.stop <= 1'b0;
        pwr.reduced <= 1'b1;
        repeat (6400) @(posedge clk);
        pwr.reduced <= 1'b0;
        wr(`SWD_ADDR_FLAGCTL, 8'h03);
        chk_reg(`SWD_ADDR_STS, 8'h04);
        wr(`SWD_ADDR_STS, 8'h04);
        chk_reg(`SWD_ADDR_STS, 8'h00);
        while (sys_reset !== 1'b1 && n < 70000) begin
            @(posedge clk);
            #1 n++;
        end
        // Prescaler phase leaves up to one reduced tick of slack
        want = expiry(0, 1000, 6400);
        `CHK((cyc - t0 > want - 80) && (cyc - t0 < want + 80), 1'b1)
        @(posedge clk);
        #1 `CHK(sys_reset, 1'b0)
        $display("test expiry done");
        repeat (3) @(posedge clk);
        chk_reg(`SWD_ADDR_FLAGCTL, 8'h0E);
        chk_reg(`SWD_ADDR_CLKCTL, `SWD_CLKCTL_RST);
        chk_reg(`SWD_ADDR_STS, 8'h03);
        `CHK(irq, 1'b1)
        `CHK(wdt_irq, 1'b0)
        wr(`SWD_ADDR_XIEN, 8'h10);
        repeat (2) @(posedge clk);
        #1 `CHK(wdt_irq, 1'b1)
        wr(`SWD_ADDR_STS, 8'h01);
        repeat (2) @(posedge clk);
        #1 `CHK(irq, 1'b0)
        chk_reg(`SWD_ADDR_STS, 8'h02);
        wr(`SWD_ADDR_FLAGCTL, 8'h02);
        chk_reg(`SWD_ADDR_FLAGCTL, 8'h02);
        `CHK(wdt_irq, 1'b0)
        $display("test flags done");
        results();
    end
endmodule
`default_nettype wire
